// >>> card_counter_pkg.sv
package card_counter_pkg;

  // ==========================================================
  // Memory layout
  localparam int CELL_COUNT = 104;
  localparam int ROM_BITS = 16;
  localparam int AREA2_LO = 16;
  localparam int AREA3_LO = 64;
  localparam int FLAG_BIT = 64;
  localparam int STAGE_BITS = 8;
  localparam int STAGE3_LO = 72;
  localparam int STAGE2_LO = 80;
  localparam int TC_LO = 88;
  localparam int EC_LO = 96;
  localparam int ADDR_W = 7;
  localparam int MAX_COUNT_UNITS = 20480;

  // ==========================================================
  // Contents after reset (values are arbitrary)
  localparam logic [15:0] ROM_CONTENT = 16'h5a3c;
  localparam logic [7:0] TC_CODE = 8'ha5;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int WRITE_HOLD_NS = 5000000;
  localparam int WRITE_HOLD_CYC =
    (WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_W = 20;

  // ==========================================================
  // Register map (byte addresses)
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] OPCNT_OFS = 12'h008;
  localparam logic [11:0] MEM0_OFS = 12'h010;
  localparam logic [11:0] MEM1_OFS = 12'h014;
  localparam logic [11:0] MEM2_OFS = 12'h018;
  localparam logic [11:0] MEM3_OFS = 12'h01c;
  localparam logic CTRL_RESET = 1'h1;

  typedef enum logic [1:0] {
    LC_DELIVERED = 2'h0,
    LC_UNLOCKED = 2'h1,
    LC_PERSONAL = 2'h3
  } life_t;

  function automatic logic in_tc(input logic [6:0] a);
    in_tc = (a >= 7'(TC_LO)) && (a < 7'(EC_LO));
  endfunction

  function automatic logic in_ec(input logic [6:0] a);
    in_ec = (a >= 7'(EC_LO)) && (a < 7'(CELL_COUNT));
  endfunction

endpackage

// >>> card_counter.sv
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module card_counter
  import card_counter_pkg::*;
#(
  parameter int unsigned WRITE_HOLD = WRITE_HOLD_CYC
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Reader link
  input wire logic reader_clock_in,
  input wire logic card_reset_in,
  input wire logic data_in,
  output logic data_out,
  output logic data_oe
);

  // ==========================================================
  // Link domain: bit address counter
  logic link_clr;
  logic [ADDR_W-1:0] addr_bin_r;
  logic [ADDR_W-1:0] addr_gray_r;
  logic [ADDR_W-1:0] addr_bin_nxt;

  // Reader reset clears the address even while its clock stands still
  assign link_clr = card_reset_in | ~presetn;
  assign addr_bin_nxt = addr_bin_r + 7'h01;

  // Modulo 128 so every step changes one gray bit across the crossing
  always_ff @(posedge reader_clock_in or posedge link_clr) begin
    if (link_clr) begin
      addr_bin_r <= 7'h00;
    end else begin
      addr_bin_r <= addr_bin_nxt;
    end
  end

  // Gray copy is registered so only one bit moves per step
  always_ff @(posedge reader_clock_in or posedge link_clr) begin
    if (link_clr) begin
      addr_gray_r <= 7'h00;
    end else begin
      addr_gray_r <= addr_bin_nxt ^ (addr_bin_nxt >> 1);
    end
  end

  // ==========================================================
  // Crossings into pclk
  logic [ADDR_W-1:0] gray_m_r;
  logic [ADDR_W-1:0] gray_s_r;
  logic [2:0] pin_raw;
  logic [2:0] pin_s;
  logic clk_s;
  logic rst_s;
  logic io_s;
  logic [ADDR_W-1:0] addr_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gray_m_r <= 7'h00;
      gray_s_r <= 7'h00;
    end else begin
      gray_m_r <= addr_gray_r;
      gray_s_r <= gray_m_r;
    end
  end

  // One two-flop synchroniser per reader pin; only the second flop reads the first
  assign pin_raw = {reader_clock_in, card_reset_in, data_in};

  for (genvar g = 0; g < 3; g++) begin : g_pin_sync
    logic meta_r;
    logic sync_r;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_r <= 1'h0;
        sync_r <= 1'h0;
      end else begin
        meta_r <= pin_raw[g];
        sync_r <= meta_r;
      end
    end

    assign pin_s[g] = sync_r;
  end

  assign clk_s = pin_s[2];
  assign rst_s = pin_s[1];
  assign io_s = pin_s[0];

  always_comb begin
    addr_s[ADDR_W-1] = gray_s_r[ADDR_W-1];
    for (int i = ADDR_W - 2; i >= 0; i--) begin
      addr_s[i] = addr_s[i+1] ^ gray_s_r[i];
    end
  end

  // ==========================================================
  // Software control
  logic prog_en_r;
  logic [15:0] opcnt_r;

  // ==========================================================
  // Long clock-high detection for programming
  logic [HOLD_W-1:0] hold_cnt_r;
  logic prog_fire;

  // Fires once per high phase; a shorter phase only counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_r <= 20'h00000;
    end else if (!clk_s) begin
      hold_cnt_r <= 20'h00000;
    end else if (hold_cnt_r < HOLD_W'(WRITE_HOLD)) begin
      hold_cnt_r <= hold_cnt_r + 20'h00001;
    end
  end

  assign prog_fire = clk_s && prog_en_r &&
    (hold_cnt_r == HOLD_W'(WRITE_HOLD - 1));

  // ==========================================================
  // Life cycle
  logic [CELL_COUNT-1:0] cells_r;
  logic [CELL_COUNT-1:0] cells_nxt;
  logic unlocked_r;
  life_t life_r;
  life_t life_nxt;

  always_comb begin
    case (life_r)
      LC_DELIVERED: begin
        if (!cells_r[FLAG_BIT]) life_nxt = LC_PERSONAL;
        else if (unlocked_r) life_nxt = LC_UNLOCKED;
        else life_nxt = LC_DELIVERED;
      end
      LC_UNLOCKED: begin
        if (!cells_r[FLAG_BIT]) life_nxt = LC_PERSONAL;
        else if (unlocked_r) life_nxt = LC_UNLOCKED;
        else life_nxt = LC_DELIVERED;
      end
      // Written flag is final: no way back
      LC_PERSONAL: life_nxt = LC_PERSONAL;
      default: life_nxt = LC_DELIVERED;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      life_r <= LC_DELIVERED;
    end else begin
      life_r <= life_nxt;
    end
  end

  // ==========================================================
  // Transport code comparison
  logic [ADDR_W-1:0] addr_prev_r;
  logic match_r;
  logic bit_ok;
  logic code_done;

  assign bit_ok = (io_s == cells_r[addr_prev_r]);
  assign code_done = (addr_prev_r == 7'(EC_LO - 1)) &&
    (addr_s == 7'(EC_LO));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_prev_r <= 7'h00;
      match_r <= 1'h0;
    end else begin
      addr_prev_r <= addr_s;
      if (addr_s != addr_prev_r) begin
        if (addr_s == 7'(TC_LO)) begin
          match_r <= 1'h1;
        end else if (in_tc(addr_prev_r)) begin
          match_r <= match_r & bit_ok;
        end
      end
    end
  end

  // Unlock needs an error counter that is not used up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlocked_r <= 1'h0;
    end else if (rst_s || life_r == LC_PERSONAL) begin
      unlocked_r <= 1'h0;
    end else if (code_done && match_r && bit_ok &&
                 life_r == LC_DELIVERED &&
                 cells_r[EC_LO +: STAGE_BITS] != 8'h00) begin
      unlocked_r <= 1'h1;
    end
  end

  // ==========================================================
  // Programming: written cell is 0, erased cell is 1
  logic prog_ok;
  int lower_lo;

  // Which cells a long high phase may program in each life stage
  function automatic logic may_write(input logic [6:0] a, input life_t lc);
    logic ok;
    ok = 1'h0;
    if (a < 7'(AREA2_LO)) begin
      ok = 1'h0;
    end else if (a < 7'(AREA3_LO)) begin
      ok = (lc == LC_UNLOCKED);
    end else if (a < 7'(STAGE3_LO)) begin
      ok = (lc != LC_DELIVERED);
    end else if (a < 7'(CELL_COUNT)) begin
      ok = (lc != LC_DELIVERED) || in_ec(a);
    end
    return ok;
  endfunction

  always_comb begin
    cells_nxt = cells_r;
    prog_ok = 1'h0;
    lower_lo = 0;
    if (prog_fire) begin
      prog_ok = may_write(addr_s, life_r);
      if (prog_ok) begin
        cells_nxt[addr_s] = 1'h0;
        // Counting down a stage reloads the stage below when personalised; while unlocked only stage 3 reloads stage 2
        // Fixed stages, carry only downward: capacity cannot grow
        if (addr_s >= 7'(STAGE3_LO) && addr_s < 7'(EC_LO)) begin
          lower_lo = ((int'(addr_s) / STAGE_BITS) + 1) * STAGE_BITS;
          if (life_r == LC_PERSONAL ||
              (life_r == LC_UNLOCKED && lower_lo == STAGE2_LO)) begin
            cells_nxt[lower_lo +: STAGE_BITS] = 8'hff;
          end
        end
        if (addr_s == 7'(FLAG_BIT) && life_r == LC_UNLOCKED) begin
          cells_nxt[EC_LO +: STAGE_BITS] = 8'hff;
        end
      end
    end
  end

  // Cells stand in for nonvolatile storage and reload on presetn
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cells_r <= {8'hff, TC_CODE, 8'hff, 8'hff, 8'hff,
                  48'hffffffffffff, ROM_CONTENT};
    end else begin
      cells_r <= cells_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opcnt_r <= 16'h0000;
    end else if (prog_ok) begin
      opcnt_r <= opcnt_r + 16'h0001;
    end
  end

  // ==========================================================
  // Data line, open drain only
  logic bit_val;
  logic hide;

  assign bit_val = (addr_s < 7'(CELL_COUNT)) ? cells_r[addr_s] : 1'h1;
  assign hide = (life_r == LC_DELIVERED) && in_tc(addr_s);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= 1'h0;
      data_oe <= 1'h0;
    end else begin
      data_out <= 1'h0;
      data_oe <= !bit_val && !hide && !rst_s;
    end
  end

  // ==========================================================
  // APB slave, one wait state
  logic [127:0] mem_view;
  logic access;
  logic known;
  logic [31:0] rd_val;

  assign mem_view = {24'h000000, cells_r};
  assign access = psel && penable && !pready;

  always_comb begin
    known = 1'h1;
    rd_val = 32'h00000000;
    case (paddr)
      CTRL_OFS: rd_val = {31'h00000000, prog_en_r};
      STATUS_OFS: rd_val = {15'h0000, addr_s, 5'h00, match_r,
                            unlocked_r, rst_s, life_r};
      OPCNT_OFS: rd_val = {16'h0000, opcnt_r};
      MEM0_OFS: rd_val = mem_view[31:0];
      MEM1_OFS: rd_val = mem_view[63:32];
      MEM2_OFS: rd_val = mem_view[95:64];
      MEM3_OFS: rd_val = mem_view[127:96];
      default: known = 1'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'h0;
    end else begin
      pready <= access;
    end
  end

  // Read data stands until the next access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
      pslverr <= 1'h0;
    end else if (access) begin
      prdata <= pwrite ? 32'h00000000 : rd_val;
      pslverr <= !known;
    end else begin
      pslverr <= 1'h0;
    end
  end

  // Write lands on the edge that completes the transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prog_en_r <= CTRL_RESET;
    end else if (psel && penable && pready && pwrite &&
                 paddr == CTRL_OFS) begin
      prog_en_r <= pwdata[0];
    end
  end

endmodule // card_counter
`default_nettype wire

// >>> card_counter_sva.sv
`timescale 1ns/1ps
`default_nettype none
module card_counter_sva
  import card_counter_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // Reader link
  input wire logic card_reset_in,
  input wire logic data_out,
  input wire logic data_oe
);
  logic mapped;
  assign mapped = paddr inside {CTRL_OFS, STATUS_OFS, OPCNT_OFS,
    MEM0_OFS, MEM1_OFS, MEM2_OFS, MEM3_OFS};
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ========
  // Bus
  chk_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("no answer after one wait");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready too long");
  chk_ready_cause: assert property (pready |-> $past(psel) && $past(penable))
    else $error("ready without access");
  chk_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_err_unmapped: assert property (pready && !mapped |-> pslverr)
    else $error("unmapped not refused");
  chk_ok_mapped: assert property (pready && mapped |-> !pslverr)
    else $error("mapped refused");
  // ========
  // Link
  chk_open_drain: assert property (data_out == 1'h0)
    else $error("data line driven high");
  // Async reset needs a few cycles through the synchroniser
  chk_reset_quiet: assert property (card_reset_in [*6] |-> !data_oe)
    else $error("drive during card reset");
endmodule // card_counter_sva
bind card_counter card_counter_sva chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .card_reset_in(card_reset_in),
  .data_out(data_out), .data_oe(data_oe));
`default_nettype wire

// >>> card_reader.sv
`timescale 1ns/1ps
`default_nettype none
module card_reader
  import card_counter_pkg::*;
#(
  parameter int HOLD = 20
) (
  // Reader link
  output logic reader_clock_in,
  output logic card_reset_in,
  output logic data_line,
  input wire logic data_oe,
  // Scenario control
  input wire logic code_en
);
  int cur;
  logic pull;
  // ========
  // Wire with pull-up; reader pulls low only for code entry
  always_comb pull = code_en && cur >= TC_LO && cur < EC_LO
    && !TC_CODE[cur - TC_LO];
  assign data_line = !(data_oe || pull);
  initial begin
    reader_clock_in = 1'h0;
    card_reset_in = 1'h0;
    cur = 0;
  end
  task rst;
    #3;
    card_reset_in = 1'h1;
    #50000;
    card_reset_in = 1'h0;
    #200;
    cur = 0;
  endtask
  // Code bit moves at the fall so the card compares a settled level
  // Small offset keeps link edges off the pclk edges
  task step(input int hold_ns);
    #3;
    reader_clock_in = 1'h1;
    #(hold_ns);
    reader_clock_in = 1'h0;
    cur = (cur + 1) % 128;
    #40;
  endtask
  task goto(input int n);
    while (cur != n) step(40);
  endtask
  task prog(input int n);
    goto((n + 127) % 128);
    step((HOLD + 8) * 10);
  endtask
endmodule // card_reader
`default_nettype wire

// >>> tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import card_counter_pkg::*;;
  localparam int WH = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr, a;
  logic [31:0] pwdata, prdata, q, seed;
  logic e, rck, rrst, din, doe, dout, code_en;
  logic [127:0] sh;
  int failures, samples_checked;
  card_counter #(.WRITE_HOLD(WH)) card_counter_i (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .reader_clock_in(rck), .card_reset_in(rrst),
    .data_in(din), .data_out(dout), .data_oe(doe));
  card_reader #(.HOLD(WH)) rd (.reader_clock_in(rck),
    .card_reset_in(rrst), .data_line(din), .data_oe(doe),
    .code_en(code_en));
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // ========
  // Helpers
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (n >= 50) begin
      failures++;
      wrap_up;
    end
  endtask
  task mem_chk;
    logic [31:0] m;
    for (int i = 0; i < 4; i++) begin
      m = (i == 3) ? 32'h0000_00ff : 32'hffff_ffff;
      apb(1'h0, MEM0_OFS + 12'(4 * i), 32'h0);
      chk(q & m, sh[32 * i +: 32] & m);
    end
  endtask
  task life(input logic [1:0] l);
    apb(1'h0, STATUS_OFS, 32'h0);
    chk(q & 32'h3, {30'h0, l});
  endtask
  task see(input logic exp_oe);
    repeat (8) @(posedge pclk);
    chk({30'h0, dout, doe}, {31'h0, exp_oe});
  endtask
  function automatic logic [31:0] next_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  initial begin
    #1000000;
    failures++;
    wrap_up;
  end
  // ========
  // Main sequence
  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    code_en = 1'h0;
    failures = 0;
    samples_checked = 0;
    seed = 32'h0000_0060;
    sh = '1;
    sh[15:0] = ROM_CONTENT;
    sh[95:88] = TC_CODE;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(q & 32'h1, {31'h0, CTRL_RESET});
    life(2'h0);
    mem_chk;
    for (int i = 0; i < 6; i++) begin
      q = next_rand();
      a = {q[9:0], 2'h0};
      if (a < 12'h020) a = a + 12'h100;
      apb(1'h1, a, q);
      apb(1'h0, a, 32'h0);
      chk(q, 32'h0);
      chk({31'h0, e}, 32'h1);
    end
    rd.rst;
    for (int i = 0; i < 24; i++) begin
      see(~sh[i]);
      rd.step(40);
    end
    rd.prog(16);
    mem_chk;
    rd.goto(89);
    see(1'h0);
    rd.prog(96);
    sh[96] = 1'h0;
    mem_chk;
    code_en <= 1'h1;
    rd.rst;
    rd.goto(96);
    code_en <= 1'h0;
    life(2'h1);
    rd.prog(0);
    mem_chk;
    rd.prog(16);
    sh[16] = 1'h0;
    mem_chk;
    rd.prog(64);
    sh[64] = 1'h0;
    sh[103:96] = 8'hff;
    mem_chk;
    life(2'h3);
    rd.prog(17);
    mem_chk;
    rd.prog(80);
    sh[80] = 1'h0;
    sh[95:88] = 8'hff;
    mem_chk;
    rd.prog(72);
    sh[72] = 1'h0;
    sh[87:80] = 8'hff;
    mem_chk;
    rd.prog(96);
    sh[96] = 1'h0;
    mem_chk;
    rd.prog(88);
    sh[88] = 1'h0;
    sh[103:96] = 8'hff;
    mem_chk;
    apb(1'h1, CTRL_OFS, 32'h0);
    apb(1'h0, CTRL_OFS, 32'h0);
    chk(q & 32'h1, 32'h0);
    rd.prog(100);
    mem_chk;
    apb(1'h0, OPCNT_OFS, 32'h0);
    chk(q, 32'h7);
    wrap_up;
  end
endmodule // tb
`default_nettype wire
